// *** eeprom_cmd_pkg.sv ***
`default_nettype none
package eeprom_cmd_pkg;
	// Parameter word geometry
	localparam int          WORD_W         = 16;
	localparam int          NUM_PARAM      = 6;
	localparam int          ADDR_W         = 24;
	localparam int          CMD_MSB        = 15;
	localparam int          CMD_LSB        = 8;
	localparam int          ADDR_HI_MSB    = 7;
	// Parameter word positions
	localparam logic [2:0]  PW_CMD         = 3'h0;
	localparam logic [2:0]  PW_ADDR_LO     = 3'h1;
	localparam logic [2:0]  PW_COUNT       = 3'h2;
	localparam logic [2:0]  PW_DATA0       = 3'h2;
	// Command codes
	localparam logic [7:0]  CMD_BLANK      = 8'h10;
	localparam logic [7:0]  CMD_PROGRAM    = 8'h11;
	// Index values accepted at launch
	localparam logic [2:0]  IDX_BLANK      = 3'h2;
	localparam logic [2:0]  IDX_PROG_MIN   = 3'h2;
	localparam logic [2:0]  IDX_PROG_MAX   = 3'h5;
	// Array content and reset values
	localparam logic [15:0] ERASED_WORD    = 16'hffff;
	localparam logic        RST_COMPLETE   = 1'b1;
	localparam logic [2:0]  RST_INDEX      = 3'h0;
	localparam logic [15:0] RST_WORD       = 16'h0000;
	// Default placement of the block in the global map
	localparam logic [23:0] EE_BASE_DEF    = 24'h100000;
	localparam logic [23:0] EE_SIZE_DEF    = 24'h000800;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RD   = 2'b01,
		ST_WR   = 2'b10,
		ST_VRD  = 2'b11
	} seq_state_t;
endpackage
`default_nettype wire

// *** param_words.sv ***
`timescale 1ns/1ps
`default_nettype none
module param_words
	import eeprom_cmd_pkg::*;
#(
	parameter int W     = WORD_W,
	parameter int DEPTH = NUM_PARAM
)
(
	// Clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               arst_n_i,
	input  wire logic               clk_en_i,
	// Write port
	input  wire logic               wr_i,
	input  wire logic [2:0]         wr_index_i,
	input  wire logic [W-1:0]       wr_data_i,
	// All stored words, straight from registers
	output logic      [DEPTH*W-1:0] words_o
);
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_word
			// One register per word; indexes past the end are dropped
			always_ff @(posedge clk_sys_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					words_o[g*W +: W] <= RST_WORD;
				else if (clk_en_i && wr_i && (wr_index_i == 3'(g)))
					words_o[g*W +: W] <= wr_data_i;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** eeprom_verify_program_cmds.sv ***
// Functional notes
// RULE_01 - Blank check: code 0x10, start, word count
// RULE_02 - Blank check reads range, then completes
// RULE_03 - Non-erased word sets both status bits
// RULE_04 - Blank check needs index 010
// RULE_05 - Command not allowed in mode: error
// RULE_06 - Address outside block: access error
// RULE_07 - Odd address: access error
// RULE_08 - Blank range past block end: error
// RULE_09 - Read errors set status; no protection flag
// RULE_10 - Program: code 0x11, address, four values
// RULE_11 - Index at launch gives word count
// RULE_12 - Program index outside 010..101: error
// RULE_13 - Program group past block end: error
// RULE_14 - Protected area: protection flag, no write
// RULE_15 - Readback verify sets status bits
// RULE_16 - Software programs only erased words
// RULE_17 - Launch error completes without array access
`timescale 1ns/1ps
`default_nettype none
module eeprom_verify_program_cmds
	import eeprom_cmd_pkg::*;
#(
	parameter logic [23:0] EE_BASE = EE_BASE_DEF,
	parameter logic [23:0] EE_SIZE = EE_SIZE_DEF
)
(
	// Clock, reset, enable
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	input  wire logic              clk_en_i,
	// Software parameter loading and launch
	input  wire logic              index_wr_i,
	input  wire logic [2:0]        index_value_i,
	input  wire logic              word_wr_i,
	input  wire logic [WORD_W-1:0] word_data_i,
	input  wire logic              launch_i,
	input  wire logic              err_clear_i,
	// Mode and protection configuration
	input  wire logic              blank_allowed_i,
	input  wire logic              prog_allowed_i,
	input  wire logic              prot_en_i,
	input  wire logic [ADDR_W-1:0] prot_lo_i,
	input  wire logic [ADDR_W-1:0] prot_hi_i,
	// Status
	output logic [2:0]             parameter_index_o,
	output logic                   command_complete_flag_o,
	output logic                   access_error_flag_o,
	output logic                   protection_violation_flag_o,
	output logic                   verify_status_hi_o,
	output logic                   verify_status_lo_o,
	// EEPROM array port
	output logic                   arr_req_o,
	output logic                   arr_write_o,
	output logic [ADDR_W-1:0]      arr_addr_o,
	output logic [WORD_W-1:0]      arr_wdata_o,
	input  wire logic              arr_ack_i,
	input  wire logic [WORD_W-1:0] arr_rdata_i,
	input  wire logic              arr_err_i,
	input  wire logic              arr_uncorr_i
);
	localparam logic [24:0] EE_END = {1'b0, EE_BASE} + {1'b0, EE_SIZE};

	logic [NUM_PARAM*WORD_W-1:0] words;
	seq_state_t                  state;
	logic [15:0]                 remain;
	logic [2:0]                  word_sel;

	// Pick one parameter word out of the flat store
	function automatic logic [WORD_W-1:0] word_at(input logic [NUM_PARAM*WORD_W-1:0] v,
		input logic [2:0] i);
		word_at = v[int'(i)*WORD_W +: WORD_W];
	endfunction

	// Words may only change while no command runs
	param_words #(
		.W     (WORD_W),
		.DEPTH (NUM_PARAM)
	) u_words (
		.clk_sys_i  (clk_sys_i),
		.arst_n_i   (arst_n_i),
		.clk_en_i   (clk_en_i),
		.wr_i       (word_wr_i && command_complete_flag_o),
		.wr_index_i (parameter_index_o),
		.wr_data_i  (word_data_i),
		.words_o    (words)
	);

	// Index register, frozen while busy
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			parameter_index_o <= RST_INDEX;
		else if (clk_en_i && index_wr_i && command_complete_flag_o)
			parameter_index_o <= index_value_i;
	end

	// Launch decode
	logic [7:0]        cmd;
	logic [ADDR_W-1:0] gaddr;
	logic              is_blank;
	logic              is_prog;
	logic [2:0]        n_words;
	logic [24:0]       span_end;
	logic              launch_ok;
	logic              launch_acc;
	logic              launch_prot;

	assign cmd      = word_at(words, PW_CMD)[CMD_MSB:CMD_LSB]; // RULE_01 RULE_10
	assign gaddr    = {word_at(words, PW_CMD)[ADDR_HI_MSB:0], word_at(words, PW_ADDR_LO)};
	assign is_blank = (cmd == CMD_BLANK);
	assign is_prog  = (cmd == CMD_PROGRAM);
	assign n_words  = 3'(parameter_index_o - 3'h1); // RULE_11
	// Exclusive end byte address of the touched range, one bit wider to catch wrap
	assign span_end = is_blank ? {1'b0, gaddr} + {8'h00, word_at(words, PW_COUNT), 1'b0}
		: {1'b0, gaddr} + {21'h000000, n_words, 1'b0};
	assign launch_ok = clk_en_i && launch_i && command_complete_flag_o
		&& !access_error_flag_o && !protection_violation_flag_o;

	// Unknown codes are refused like any other illegal launch
	always_comb
	begin
		launch_acc = 1'b0;
		if (!is_blank && !is_prog)
			launch_acc = 1'b1;
		if (is_blank && (parameter_index_o != IDX_BLANK))
			launch_acc = 1'b1; // RULE_04
		if (is_prog && ((parameter_index_o < IDX_PROG_MIN) || (parameter_index_o > IDX_PROG_MAX)))
			launch_acc = 1'b1; // RULE_12
		if ((is_blank && !blank_allowed_i) || (is_prog && !prog_allowed_i))
			launch_acc = 1'b1; // RULE_05
		if (({1'b0, gaddr} < {1'b0, EE_BASE}) || ({1'b0, gaddr} >= EE_END))
			launch_acc = 1'b1; // RULE_06
		if (gaddr[0])
			launch_acc = 1'b1; // RULE_07
		if (span_end > EE_END)
			launch_acc = 1'b1; // RULE_08 RULE_13
	end

	// Only programming checks protection; blank check never flags it
	assign launch_prot = is_prog && prot_en_i && (gaddr <= prot_hi_i)
		&& (span_end > {1'b0, prot_lo_i}); // RULE_14 RULE_09

	// Array completion events
	logic rd_done;
	logic ver_done;
	logic bad_data;
	logic ev_hi;
	logic ev_lo;
	logic finish;

	assign rd_done  = clk_en_i && (state == ST_RD) && arr_ack_i;
	assign ver_done = clk_en_i && (state == ST_VRD) && arr_ack_i;
	// Readback mismatch is treated as non-correctable
	assign bad_data = (rd_done && (arr_rdata_i != ERASED_WORD))
		|| (ver_done && (arr_rdata_i != arr_wdata_o)); // RULE_03 RULE_15
	assign ev_hi  = (rd_done || ver_done) && (arr_err_i || arr_uncorr_i || bad_data); // RULE_09
	assign ev_lo  = (rd_done || ver_done) && (arr_uncorr_i || bad_data); // RULE_09
	assign finish = (rd_done || ver_done) && (remain == 16'h0001);

	// Sequencer driving the array
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state       <= ST_IDLE;
			remain      <= 16'h0000;
			word_sel    <= 3'h0;
			arr_req_o   <= 1'b0;
			arr_write_o <= 1'b0;
			arr_addr_o  <= '0;
			arr_wdata_o <= RST_WORD;
		end
		else if (clk_en_i)
		begin
			case (state)
				ST_IDLE:
				begin
					if (launch_ok && !launch_acc && !launch_prot) // RULE_17
					begin
						arr_addr_o <= gaddr;
						if (is_blank && (word_at(words, PW_COUNT) != 16'h0000))
						begin
							remain      <= word_at(words, PW_COUNT);
							arr_req_o   <= 1'b1; // RULE_02
							arr_write_o <= 1'b0;
							state       <= ST_RD;
						end
						else if (is_prog)
						begin
							remain      <= {13'h0000, n_words};
							word_sel    <= 3'h0;
							arr_wdata_o <= word_at(words, PW_DATA0);
							arr_req_o   <= 1'b1;
							arr_write_o <= 1'b1;
							state       <= ST_WR;
						end
					end
				end
				ST_RD:
				begin
					if (arr_ack_i)
					begin
						remain     <= 16'(remain - 16'h0001);
						arr_addr_o <= 24'(arr_addr_o + 24'h000002);
						if (finish)
						begin
							arr_req_o <= 1'b0;
							state     <= ST_IDLE;
						end
					end
				end
				ST_WR:
				begin
					// Every written word is read back before the next
					if (arr_ack_i)
					begin
						arr_write_o <= 1'b0;
						state       <= ST_VRD; // RULE_15
					end
				end
				ST_VRD:
				begin
					if (arr_ack_i)
					begin
						remain <= 16'(remain - 16'h0001);
						if (finish)
						begin
							arr_req_o <= 1'b0;
							state     <= ST_IDLE;
						end
						else
						begin
							word_sel    <= 3'(word_sel + 3'h1);
							arr_addr_o  <= 24'(arr_addr_o + 24'h000002);
							arr_wdata_o <= word_at(words, 3'(PW_DATA0 + word_sel + 3'h1));
							arr_write_o <= 1'b1;
							state       <= ST_WR;
						end
					end
				end
				default:
				begin
					arr_req_o <= 1'b0;
					state     <= ST_IDLE;
				end
			endcase
		end
	end

	// Completion flag: cleared by a clean launch unless a blank check has count zero, set when the sequence ends
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			command_complete_flag_o <= RST_COMPLETE;
		else if (clk_en_i)
		begin
			if (launch_ok)
				command_complete_flag_o <= launch_acc || launch_prot
					|| (is_blank && (word_at(words, PW_COUNT) == 16'h0000)); // RULE_17
			else if (finish)
				command_complete_flag_o <= 1'b1; // RULE_02 RULE_11
		end
	end

	// Error flags: a set in the clear cycle wins
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			access_error_flag_o         <= 1'b0;
			protection_violation_flag_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (launch_ok && launch_acc)
				access_error_flag_o <= 1'b1;
			else if (err_clear_i)
				access_error_flag_o <= 1'b0;
			if (launch_ok && !launch_acc && launch_prot)
				protection_violation_flag_o <= 1'b1; // RULE_14
			else if (err_clear_i)
				protection_violation_flag_o <= 1'b0;
		end
	end

	// Verify status: cleared by each launch, sticky over the run
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			verify_status_hi_o <= 1'b0;
			verify_status_lo_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (launch_ok)
			begin
				verify_status_hi_o <= 1'b0;
				verify_status_lo_o <= 1'b0;
			end
			else
			begin
				if (ev_hi)
					verify_status_hi_o <= 1'b1; // RULE_03 RULE_09 RULE_15
				if (ev_lo)
					verify_status_lo_o <= 1'b1;
			end
		end
	end

	chk_acc_completes: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_17
		launch_ok && launch_acc |=> access_error_flag_o && command_complete_flag_o && !arr_req_o)
		else $error("access error launch did not complete at once");
	chk_prot_flagged: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_14
		launch_ok && !launch_acc && launch_prot |=> protection_violation_flag_o && !arr_req_o)
		else $error("protected program was not refused");
	chk_good_launch: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_02
		launch_ok && !launch_acc && !launch_prot && is_prog |=> !command_complete_flag_o && arr_req_o)
		else $error("clean launch did not start the array");
	chk_blank_index: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_04
		launch_ok && is_blank && (parameter_index_o != IDX_BLANK) |=> access_error_flag_o)
		else $error("blank check index not refused");
	chk_prog_index: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_12
		launch_ok && is_prog && ((parameter_index_o < IDX_PROG_MIN) || (parameter_index_o > IDX_PROG_MAX))
		|=> access_error_flag_o)
		else $error("program index not refused");
	chk_odd_address: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_07
		launch_ok && gaddr[0] |=> access_error_flag_o)
		else $error("misaligned address not refused");
	chk_mode_refused: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_05
		launch_ok && is_prog && !prog_allowed_i |=> access_error_flag_o)
		else $error("program outside its mode not refused");
	chk_status_pair: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_09
		verify_status_lo_o |-> verify_status_hi_o)
		else $error("low status bit without high status bit");
	chk_blank_fail: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_03
		rd_done && (arr_rdata_i != ERASED_WORD) |=> verify_status_hi_o && verify_status_lo_o)
		else $error("non-erased word did not set both status bits");
	chk_verify_first: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // RULE_15
		clk_en_i && (state == ST_WR) && arr_ack_i |=> (state == ST_VRD) && !arr_write_o)
		else $error("written word not read back");
endmodule
`default_nettype wire

// *** eeprom_array_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module eeprom_array_model
	import eeprom_cmd_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	// Bench controls: slow answers, injected read errors
	input  wire logic              slow_i,
	input  wire logic              err_inj_i,
	input  wire logic              unc_inj_i,
	// Array port
	input  wire logic              req_i,
	input  wire logic              write_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [WORD_W-1:0] wdata_i,
	output logic                   ack_o,
	output logic [WORD_W-1:0]      rdata_o,
	output logic                   err_o,
	output logic                   uncorr_o
);
	logic [WORD_W-1:0] mem [0:1023];
	logic [1:0]        wait_cnt;
	logic              go;

	// Array starts erased; contents survive a controller reset
	initial
	begin
		foreach (mem[k])
			mem[k] = ERASED_WORD;
		rdata_o = 16'h5a5a;
	end

	assign go = req_i && !ack_o && (wait_cnt >= (slow_i ? 2'h3 : 2'h0));

	// One ack pulse per transfer, after a short or long wait
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ack_o    <= 1'b0;
			wait_cnt <= 2'h0;
		end
		else
		begin
			ack_o    <= go;
			wait_cnt <= (req_i && !ack_o && !go) ? wait_cnt + 2'h1 : 2'h0;
		end
	end

	// Data is only valid with ack; otherwise rdata toggles so stale values never pass
	always @(posedge clk_sys_i)
	begin
		if (go && write_i)
			mem[addr_i[10:1]] <= wdata_i;
		rdata_o  <= go ? mem[addr_i[10:1]] : ~rdata_o;
		err_o    <= go && !write_i && err_inj_i;
		uncorr_o <= go && !write_i && unc_inj_i;
	end
endmodule
`default_nettype wire

// *** eeprom_verify_program_cmds_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			fails++; \
			$display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end
module eeprom_verify_program_cmds_bench
	import eeprom_cmd_pkg::*;
;
	// cfg: blank ok, program ok, protect on, read error, uncorrectable, slow
	// exp: access error, protection, status hi, status lo
	typedef struct packed {
		logic [7:0]  cmd;
		logic [23:0] addr;
		logic [2:0]  idx;
		logic [15:0] d2;
		logic [5:0]  cfg;
		logic [3:0]  exp;
	} row_t;

	logic              clk_sys_i;
	logic              arst_n_i;
	logic              clk_en_i;
	logic              index_wr_i;
	logic [2:0]        index_value_i;
	logic              word_wr_i;
	logic [WORD_W-1:0] word_data_i;
	logic              launch_i;
	logic              err_clear_i;
	logic [5:0]        cfg;
	logic [2:0]        parameter_index_o;
	logic              command_complete_flag_o;
	logic              access_error_flag_o;
	logic              protection_violation_flag_o;
	logic              verify_status_hi_o;
	logic              verify_status_lo_o;
	logic              arr_req_o;
	logic              arr_write_o;
	logic [ADDR_W-1:0] arr_addr_o;
	logic [WORD_W-1:0] arr_wdata_o;
	logic              arr_ack_i;
	logic [WORD_W-1:0] arr_rdata_i;
	logic              arr_err_i;
	logic              arr_uncorr_i;
	logic [3:0]        flags;
	int                fails;
	int                samples_checked;
	int                acks;

	// Programs only ever target erased words
	row_t rows [23] = '{
		'{8'h11, 24'h100000, 3'h2, 16'h1234, 6'b110000, 4'h0},
		'{8'h11, 24'h100010, 3'h5, 16'h0a0a, 6'b110001, 4'h0},
		'{8'h10, 24'h100020, 3'h2, 16'h0004, 6'b110000, 4'h0},
		'{8'h10, 24'h100000, 3'h2, 16'h0001, 6'b110000, 4'h3},
		'{8'h10, 24'h100020, 3'h3, 16'h0004, 6'b110000, 4'h8},
		'{8'h10, 24'h100020, 3'h2, 16'h0004, 6'b010000, 4'h8},
		'{8'h11, 24'h100040, 3'h2, 16'h0001, 6'b100000, 4'h8},
		'{8'h11, 24'h100800, 3'h2, 16'h0001, 6'b110000, 4'h8},
		'{8'h11, 24'h100041, 3'h2, 16'h0001, 6'b110000, 4'h8},
		'{8'h10, 24'h1007fe, 3'h2, 16'h0002, 6'b110000, 4'h8},
		'{8'h10, 24'h1007fe, 3'h2, 16'h0001, 6'b110000, 4'h0},
		'{8'h10, 24'h100020, 3'h2, 16'h0000, 6'b110000, 4'h0},
		'{8'h11, 24'h100040, 3'h1, 16'h0001, 6'b110000, 4'h8},
		'{8'h11, 24'h100040, 3'h6, 16'h0001, 6'b110000, 4'h8},
		'{8'h11, 24'h1007fc, 3'h4, 16'h0001, 6'b110000, 4'h8},
		'{8'h11, 24'h100700, 3'h2, 16'h5555, 6'b111000, 4'h4},
		'{8'h10, 24'h100700, 3'h2, 16'h0002, 6'b111000, 4'h0},
		'{8'h10, 24'h100080, 3'h2, 16'h0002, 6'b110100, 4'h2},
		'{8'h10, 24'h100080, 3'h2, 16'h0002, 6'b110010, 4'h3},
		'{8'h11, 24'h100090, 3'h2, 16'h7777, 6'b110100, 4'h2},
		'{8'h11, 24'h1000a0, 3'h3, 16'h6666, 6'b110010, 4'h3},
		'{8'h11, 24'h1007fc, 3'h3, 16'h4444, 6'b110000, 4'h0},
		'{8'h12, 24'h100040, 3'h2, 16'h0001, 6'b110000, 4'h8}
	};

	assign flags = {access_error_flag_o, protection_violation_flag_o,
		verify_status_hi_o, verify_status_lo_o};

	eeprom_verify_program_cmds u_dut (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
		.index_wr_i(index_wr_i), .index_value_i(index_value_i),
		.word_wr_i(word_wr_i), .word_data_i(word_data_i), .launch_i(launch_i),
		.err_clear_i(err_clear_i), .blank_allowed_i(cfg[5]), .prog_allowed_i(cfg[4]),
		.prot_en_i(cfg[3]), .prot_lo_i(24'h100700), .prot_hi_i(24'h1007ff),
		.parameter_index_o(parameter_index_o),
		.command_complete_flag_o(command_complete_flag_o),
		.access_error_flag_o(access_error_flag_o),
		.protection_violation_flag_o(protection_violation_flag_o),
		.verify_status_hi_o(verify_status_hi_o), .verify_status_lo_o(verify_status_lo_o),
		.arr_req_o(arr_req_o), .arr_write_o(arr_write_o), .arr_addr_o(arr_addr_o),
		.arr_wdata_o(arr_wdata_o), .arr_ack_i(arr_ack_i), .arr_rdata_i(arr_rdata_i),
		.arr_err_i(arr_err_i), .arr_uncorr_i(arr_uncorr_i));

	eeprom_array_model u_arr (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .slow_i(cfg[0]),
		.err_inj_i(cfg[2]), .unc_inj_i(cfg[1]), .req_i(arr_req_o),
		.write_i(arr_write_o), .addr_i(arr_addr_o), .wdata_i(arr_wdata_o),
		.ack_o(arr_ack_i), .rdata_o(arr_rdata_i), .err_o(arr_err_i),
		.uncorr_o(arr_uncorr_i));

	// 50 MHz clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever
			#10 clk_sys_i = ~clk_sys_i;
	end

	// Count array transfers of the current command
	always @(posedge clk_sys_i)
		if (arr_ack_i === 1'b1)
			acks++;

	function automatic int exp_acks(input row_t r);
		if (r.exp[3:2] != 2'b00)
			return 0;
		return (r.cmd == CMD_BLANK) ? int'(r.d2) : 2 * (int'(r.idx) - 1);
	endfunction

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Word write and index write share an edge, so the word lands at the old index
	task automatic start(input row_t r);
		logic [15:0] w [6];
		w = '{{r.cmd, r.addr[23:16]}, r.addr[15:0], r.d2, 16'h0b0a, 16'h0b0b, 16'h0b0c};
		@(posedge clk_sys_i);
		index_wr_i    <= 1'b1;
		index_value_i <= 3'h0;
		for (int k = 0; k < 6; k++)
		begin
			@(posedge clk_sys_i);
			word_wr_i     <= 1'b1;
			word_data_i   <= w[k];
			index_value_i <= (k == 5) ? r.idx : 3'(k + 1);
		end
		@(posedge clk_sys_i);
		index_wr_i <= 1'b0;
		word_wr_i  <= 1'b0;
		cfg        <= r.cfg;
		acks = 0;
		@(posedge clk_sys_i);
		launch_i <= 1'b1;
		@(posedge clk_sys_i);
		launch_i <= 1'b0;
	endtask

	// Status lands one edge after the final ack, so settle two cycles
	task automatic run(input row_t r);
		bit done;
		done = 1'b0;
		start(r);
		for (int n = 0; n < 300 && !done; n++)
		begin
			@(negedge clk_sys_i);
			done = (command_complete_flag_o === 1'b1);
		end
		repeat (2) @(negedge clk_sys_i);
		`CHECK(command_complete_flag_o, 1'b1)
		`CHECK(flags, r.exp)
		`CHECK(acks, exp_acks(r))
	endtask

	task automatic clear;
		@(posedge clk_sys_i);
		err_clear_i <= 1'b1;
		@(posedge clk_sys_i);
		err_clear_i <= 1'b0;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		fails++;
		give_verdict();
	end

	initial
	begin
		{arst_n_i, index_wr_i, index_value_i, word_wr_i, word_data_i} = '0;
		{launch_i, err_clear_i, cfg} = '0;
		clk_en_i = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		// Table rows cover codes, index limits, mode, address and range errors
		foreach (rows[i])
		begin
			run(rows[i]);
			clear();
			$display("row %0d finished", i);
		end
		// Placement and count of programmed words in the array
		`CHECK(u_arr.mem[0], 16'h1234)
		`CHECK(u_arr.mem[11], 16'h0b0c)
		`CHECK(u_arr.mem[12], ERASED_WORD)
		`CHECK(u_arr.mem[10'h380], ERASED_WORD)
		$display("array contents test finished");
		// A pending error refuses the next launch outright
		run(rows[4]);
		run(rows[2] | 4'h8);
		clear();
		$display("refused launch test finished");
		// A valid blank check is still loaded; with the enable low the launch must be lost
		@(posedge clk_sys_i);
		clk_en_i <= 1'b0;
		launch_i <= 1'b1;
		@(posedge clk_sys_i);
		launch_i <= 1'b0;
		@(posedge clk_sys_i);
		clk_en_i <= 1'b1;
		@(negedge clk_sys_i);
		`CHECK({command_complete_flag_o, arr_req_o}, 2'b10)
		$display("clock enable test finished");
		// Loads and launches are ignored while busy, then reset aborts the run
		start('{8'h10, 24'h100020, 3'h2, 16'h0004, 6'b110001, 4'h0});
		@(posedge clk_sys_i);
		launch_i      <= 1'b1;
		index_wr_i    <= 1'b1;
		index_value_i <= 3'h5;
		@(posedge clk_sys_i);
		launch_i   <= 1'b0;
		index_wr_i <= 1'b0;
		@(negedge clk_sys_i);
		`CHECK({command_complete_flag_o, arr_req_o, parameter_index_o}, 5'h0a)
		arst_n_i = 1'b0;
		#1;
		`CHECK({command_complete_flag_o, arr_req_o, parameter_index_o, flags}, 9'h100)
		@(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		run(rows[2]);
		$display("busy and reset test finished");
		give_verdict();
	end
endmodule
`default_nettype wire
